/* mac_data_if.sv */
`timescale 1ns/1ps
interface mac_data_if;
    logic       tx_clk;
    logic       rx_clk;
    logic       tx_en;
    logic [3:0] txd;
    logic       rx_dv;
    logic       rx_er;
    logic [3:0] rxd;
    logic       crs;
    logic       col;
    modport phy (output tx_clk, output rx_clk, input tx_en, input txd,
                 output rx_dv, output rx_er, output rxd, output crs, output col);
    modport mac (input tx_clk, input rx_clk, output tx_en, output txd,
                 input rx_dv, input rx_er, input rxd, input crs, input col);
endinterface

/* mac_if_pkg.sv */
package mac_if_pkg;
    localparam int unsigned REF_CLK_HZ      = 200_000_000;
    localparam int unsigned CLK_100_HZ      = 25_000_000;
    localparam int unsigned CLK_10_HZ       = 2_500_000;
    localparam int unsigned CLK_SER_HZ      = 10_000_000;
    localparam int unsigned CLK_RMII_HZ     = 50_000_000;
    // half periods in system cycles
    localparam int unsigned HALF_100        = REF_CLK_HZ / CLK_100_HZ / 2;
    localparam int unsigned HALF_10         = REF_CLK_HZ / CLK_10_HZ / 2;
    localparam int unsigned HALF_SER        = REF_CLK_HZ / CLK_SER_HZ / 2;
    localparam int unsigned HALF_RMII       = REF_CLK_HZ / CLK_RMII_HZ / 2;
    localparam int unsigned SQE_NS          = 1000;
    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned SQE_CYCLES      = SQE_NS / CLK_PERIOD_NS;
    localparam int unsigned DIV_W           = 8;
    localparam logic [1:0]  MODE_MII        = 2'h0;
    localparam logic [1:0]  MODE_RMII       = 2'h1;
    localparam logic [1:0]  MODE_SER        = 2'h2;
    localparam logic [3:0]  ERR_NIBBLE      = 4'he;
endpackage

/* mac_phy_side.sv */
`timescale 1ns/1ps
module mac_phy_side (
    input  wire logic       ref_clk_i,   // system clock
    input  wire logic       rst_i,       // sync reset
    input  wire logic [1:0] mode_i,      // interface mode, held stable
    input  wire logic       tx_valid_i,  // user tx data valid
    input  wire logic [3:0] tx_data_i,   // user tx data
    output logic            tx_ready_o,  // tx data taken this cycle
    output logic            rx_valid_o,  // rx data valid pulse
    output logic [3:0]      rx_data_o,   // rx data
    output logic            rx_err_o,    // rx error seen
    output logic            collision_o, // collision level
    mac_data_if.mac         phy          // phy side pins
);
    logic       txc_s1, txc_s2, txc_d;
    logic       rxc_s1, rxc_s2, rxc_d;
    logic       dv_s1, dv_s2, er_s1, er_s2, crs_s1, crs_s2, col_s1, col_s2;
    logic [3:0] rxd_s1, rxd_s2;
    logic       tx_en_q;
    logic [3:0] txd_q;
    logic [1:0] rmii_div;

    wire is_rmii  = (mode_i == mac_if_pkg::MODE_RMII);
    wire is_ser   = (mode_i == mac_if_pkg::MODE_SER);
    // rmii has no clock pin: own 50 MHz slot from the shared reference
    wire rmii_tick = (rmii_div == 2'(2 * mac_if_pkg::HALF_RMII - 1));
    wire tx_fall  = is_rmii ? rmii_tick : (txc_d && !txc_s2);
    wire rx_rise  = is_rmii ? rmii_tick : (rxc_s2 && !rxc_d);
    // R22: rmii collision from own tx enable and carrier
    wire col_now  = is_rmii ? (tx_en_q && crs_s2) : col_s2;

    always_ff @(posedge ref_clk_i) begin
        txc_s1 <= phy.tx_clk;
        txc_s2 <= txc_s1;
        txc_d  <= txc_s2;
        rxc_s1 <= phy.rx_clk;
        rxc_s2 <= rxc_s1;
        rxc_d  <= rxc_s2;
        dv_s1  <= phy.rx_dv;
        dv_s2  <= dv_s1;
        er_s1  <= phy.rx_er;
        er_s2  <= er_s1;
        crs_s1 <= phy.crs;
        crs_s2 <= crs_s1;
        col_s1 <= phy.col;
        col_s2 <= col_s1;
        rxd_s1 <= phy.rxd;
        rxd_s2 <= rxd_s1;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rmii_div <= '0;
        end else begin
            rmii_div <= rmii_div + 2'h1;
        end
    end

    assign tx_ready_o = tx_fall;

    // R4: R5: enable and data change together on tx clock fall
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            tx_en_q <= 1'b0;
            txd_q   <= '0;
        end else if (tx_fall) begin
            tx_en_q <= tx_valid_i;
            txd_q   <= !tx_valid_i ? 4'h0 :
                       is_rmii ? {2'h0, tx_data_i[1:0]} :
                       is_ser  ? {3'h0, tx_data_i[0]} : tx_data_i;
        end
    end

    assign phy.tx_en = tx_en_q;
    assign phy.txd   = txd_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rx_valid_o  <= 1'b0;
            rx_data_o   <= '0;
            rx_err_o    <= 1'b0;
            collision_o <= 1'b0;
        end else begin
            collision_o <= col_now;
            rx_valid_o  <= rx_rise && (is_ser ? crs_s2 : dv_s2);
            if (rx_rise) begin
                rx_data_o <= rxd_s2;
                rx_err_o  <= !is_ser && er_s2;
            end
        end
    end
endmodule

/* phy_mac_data_interface_properties.sv */
`timescale 1ns/1ps
module phy_mac_data_interface_properties #(
    parameter int unsigned SQE_LEN = mac_if_pkg::SQE_CYCLES
) (
    input wire logic       ref_clk_i,     // clock
    input wire logic       rst_i,         // reset
    input wire logic [1:0] mode_strap_i,  // mode
    input wire logic       speed_100_i,   // speed
    input wire logic       full_duplex_i, // duplex
    input wire logic       tx_clk,        // tx clock
    input wire logic       rx_clk,        // rx clock
    input wire logic       tx_en,         // tx enable
    input wire logic [3:0] txd,           // tx data
    input wire logic       rx_dv,         // rx valid
    input wire logic       rx_er,         // rx error
    input wire logic [3:0] rxd,           // rx data
    input wire logic       crs,           // carrier
    input wire logic       col            // collision
);
    wire logic mii  = mode_strap_i == mac_if_pkg::MODE_MII;
    wire logic rmii = mode_strap_i == mac_if_pkg::MODE_RMII;
    wire logic ser  = mode_strap_i == mac_if_pkg::MODE_SER;
    logic [15:0] quiet_cnt;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // cycles since the last tx or rx activity
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || tx_en || crs) begin
            quiet_cnt <= 16'h0;
        end else if (quiet_cnt != 16'hffff) begin
            quiet_cnt <= quiet_cnt + 16'h1;
        end
    end
    ////////////////////////////////////////////////////////////
    property p_clk_100; mii && speed_100_i && $rose(tx_clk) |-> tx_clk[*4] ##1 !tx_clk; endproperty
    a_clk_100: assert property (p_clk_100) else $error("tx clock period wrong");
    property p_clk_ser; ser && $rose(tx_clk) |-> ##9 tx_clk ##1 !tx_clk; endproperty
    a_clk_ser: assert property (p_clk_ser) else $error("serial tx clock wrong");
    property p_rmii_clk; rmii |-> !tx_clk && !rx_clk; endproperty
    a_rmii_clk: assert property (p_rmii_clk) else $error("link clock in rmii");
    property p_txd_sync; !rmii && ($changed(txd) || $changed(tx_en)) |-> !tx_clk; endproperty
    a_txd_sync: assert property (p_txd_sync) else $error("tx data moved off clock");
    property p_corrupt; rx_er |-> (rmii ? rxd[1:0] == 2'h2 : rxd == mac_if_pkg::ERR_NIBBLE);
    endproperty
    a_corrupt: assert property (p_corrupt) else $error("rx data not corrupted");
    property p_ser_unused; ser |-> !rx_dv && !rx_er && rxd[3:1] == 3'h0; endproperty
    a_ser_unused: assert property (p_ser_unused) else $error("serial unused pins set");
    property p_fd_col; full_duplex_i |-> !col; endproperty
    a_fd_col: assert property (p_fd_col) else $error("collision in full duplex");
    property p_col_cause; col |-> quiet_cnt < SQE_LEN + 200; endproperty
    a_col_cause: assert property (p_col_cause) else $error("collision without activity");
endmodule

/* phy_mac_data_interface_tb_top.sv */
`timescale 1ns/1ps
module phy_mac_data_interface_tb_top;
    localparam int unsigned SQE = 10;
    logic       ref_clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [1:0] mode_strap_i = 2'h0;
    logic       speed_100_i = 1'b1;
    logic       full_duplex_i = 1'b1;
    logic       heartbeat_en_i = 1'b0;
    logic       line_rx_act_i = 1'b0;
    logic       line_rx_valid_i = 1'b0;
    logic       line_rx_err_i = 1'b0;
    logic [3:0] line_rxd_i = 4'h0;
    logic       tx_valid_i = 1'b0;
    logic [3:0] tx_data_i = 4'h0;
    logic       tx_valid_o, tx_ready_o, rx_valid_o, rx_err_o, collision_o;
    logic [3:0] tx_data_o, rx_data_o;
    logic [3:0] tx_q[$], rx_q[$];
    logic       err_seen = 1'b0;
    int         tx_per = 8;   // link period in cycles for the mode under test
    int         tx_run = 0;   // cycles into the current sampled tx unit
    logic       col_seen = 1'b0;
    int         error_cnt = 0;
    int         num_checks = 0;
    mac_data_if link ();
    phy_mac_side #(.SQE_LEN(SQE)) u_phy_mac_side (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .mode_strap_i(mode_strap_i), .speed_100_i(speed_100_i), .full_duplex_i(full_duplex_i),
        .heartbeat_en_i(heartbeat_en_i), .line_rx_act_i(line_rx_act_i),
        .line_rx_valid_i(line_rx_valid_i), .line_rx_err_i(line_rx_err_i),
        .line_rxd_i(line_rxd_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .mac(link));
    mac_phy_side u_mac_phy_side (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .mode_i(mode_strap_i),
        .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o),
        .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .rx_err_o(rx_err_o),
        .collision_o(collision_o), .phy(link));
    phy_mac_data_interface_properties #(.SQE_LEN(SQE)) u_props (.ref_clk_i(ref_clk_i),
        .rst_i(rst_i), .mode_strap_i(mode_strap_i), .speed_100_i(speed_100_i),
        .full_duplex_i(full_duplex_i), .tx_clk(link.tx_clk), .rx_clk(link.rx_clk),
        .tx_en(link.tx_en), .txd(link.txd), .rx_dv(link.rx_dv), .rx_er(link.rx_er),
        .rxd(link.rxd), .crs(link.crs), .col(link.col));
    ////////////////////////////////////////////////////////////
    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    always @(negedge ref_clk_i) begin
        // tx_valid_o stands one link period per unit: take it once per period
        if (tx_valid_o === 1'b1) begin
            if (tx_run == 0) tx_q.push_back(tx_data_o);
            tx_run = (tx_run + 1) % tx_per;
        end else begin
            tx_run = 0;
        end
        if (rx_valid_o === 1'b1) rx_q.push_back(rx_data_o);
        if (rx_err_o === 1'b1) err_seen = 1'b1;
        if (collision_o === 1'b1) col_seen = 1'b1;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // waits for the queue to fill, then compares it item by item
    task automatic cmpq(ref logic [3:0] q[$], input logic [3:0] exp[$]);
        for (int n = 0; n < 2000 && q.size() < exp.size(); n++) @(negedge ref_clk_i);
        chk(8'(q.size()), 8'(exp.size()));
        if (q.size() < exp.size()) end_sim();
        foreach (exp[i]) if (i < q.size()) chk({4'h0, q[i]}, {4'h0, exp[i]});
    endtask
    task automatic setup(input logic [1:0] m, input logic s, input logic f, input logic h);
        rst_i = 1'b1;
        mode_strap_i = m;
        speed_100_i = s;
        full_duplex_i = f;
        heartbeat_en_i = h;
        tx_per = 2 * ((m == mac_if_pkg::MODE_RMII) ? mac_if_pkg::HALF_RMII :
                      (m == mac_if_pkg::MODE_SER)  ? mac_if_pkg::HALF_SER  :
                      s ? mac_if_pkg::HALF_100 : mac_if_pkg::HALF_10);
        repeat (5) @(negedge ref_clk_i);
        rst_i = 1'b0;
        tx_q.delete();
        rx_q.delete();
    endtask
    task automatic send(input logic [3:0] d[$]);
        foreach (d[i]) begin
            tx_valid_i = 1'b1;
            tx_data_i = d[i];
            for (int n = 0; tx_ready_o !== 1'b1; n++) begin
                @(negedge ref_clk_i);
                if (n == 300) begin
                    chk(8'h0, 8'h1);
                    end_sim();
                end
            end
            @(negedge ref_clk_i);
        end
        tx_valid_i = 1'b0;
    endtask
    task automatic recv(input logic [3:0] d[$], input int per, input logic e);
        foreach (d[i]) begin
            line_rx_act_i = 1'b1;
            line_rx_valid_i = 1'b1;
            line_rx_err_i = e;
            line_rxd_i = d[i];
            repeat (per) @(negedge ref_clk_i);
        end
        line_rx_act_i = 1'b0;
        line_rx_valid_i = 1'b0;
        line_rx_err_i = 1'b0;
    endtask
    task automatic watch_col(input int cyc);
        col_seen = 1'b0;
        for (int n = 0; n < cyc && !col_seen; n++) @(negedge ref_clk_i);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        setup(mac_if_pkg::MODE_MII, 1'b1, 1'b1, 1'b0);
        col_seen = 1'b0;
        err_seen = 1'b0;
        fork
            send('{4'ha, 4'h5, 4'hc});
            recv('{4'h3, 4'h9, 4'h6}, 8, 1'b0);
        join
        recv('{4'h7}, 8, 1'b1);
        cmpq(tx_q, '{4'ha, 4'h5, 4'hc});
        cmpq(rx_q, '{4'h3, 4'h9, 4'h6, mac_if_pkg::ERR_NIBBLE});
        chk({7'h0, err_seen}, 8'h1);
        chk({7'h0, col_seen}, 8'h0);
        $display("mii 100 test done");
        setup(mac_if_pkg::MODE_MII, 1'b0, 1'b1, 1'b1);
        send('{4'h5});
        watch_col(400);
        chk({7'h0, col_seen}, 8'h0);
        setup(mac_if_pkg::MODE_MII, 1'b0, 1'b0, 1'b1);
        send('{4'ha});
        watch_col(400);
        chk({7'h0, col_seen}, 8'h1);
        cmpq(tx_q, '{4'ha});
        $display("mii 10 test done");
        setup(mac_if_pkg::MODE_SER, 1'b0, 1'b0, 1'b0);
        col_seen = 1'b0;
        fork
            send('{4'h1, 4'h0, 4'h1, 4'h1});
            recv('{4'h1, 4'h0, 4'h1}, 20, 1'b0);
        join
        cmpq(tx_q, '{4'h1, 4'h0, 4'h1, 4'h1});
        cmpq(rx_q, '{4'h1, 4'h0, 4'h1});
        chk({7'h0, col_seen}, 8'h1);
        $display("serial test done");
        setup(mac_if_pkg::MODE_RMII, 1'b1, 1'b0, 1'b0);
        col_seen = 1'b0;
        err_seen = 1'b0;
        fork
            send('{4'h2, 4'h1, 4'h3});
            recv('{4'h1, 4'h2}, 4, 1'b0);
        join
        recv('{4'h3}, 4, 1'b1);
        cmpq(tx_q, '{4'h2, 4'h1, 4'h3});
        cmpq(rx_q, '{4'h1, 4'h2, {2'h0, mac_if_pkg::ERR_NIBBLE[1:0]}});
        chk({7'h0, err_seen}, 8'h1);
        chk({7'h0, col_seen}, 8'h1);
        $display("rmii test done");
        end_sim();
    end
endmodule

/* phy_mac_side.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////////
// Contract
// R1: mii tx clock 25 or 2.5 MHz
// R2: rmii uses shared 50 MHz reference
// R3: serial mode tx clock 10 MHz
// R4: mac drives serial data on tx clock
// R5: tx enable high exactly with data
// R6: mii tx nibble on tx clock
// R7: rmii tx dibit on 50 MHz reference
// R8: rx clock 25, 2.5 or 10 MHz
// R9: mii rx valid marks valid nibble
// R10: rmii rx valid independent of carrier
// R11: mii 100M invalid symbol raises rx error
// R12: rmii 100M media error raises rx error
// R13: rx error corrupts delivered data
// R14: mii rx nibble on rx clock
// R15: rmii rx dibit on reference clock
// R16: serial rx data on bit 0
// R17: carrier sense while medium busy
// R18: rmii combined carrier and valid
// R19: half duplex collision on tx+rx overlap
// R20: heartbeat pulse about 1us after tx
// R21: full duplex collision always low; the mac's rmii collision_o still rises on tx_en with crs
// R22: mac derives rmii collision itself
// R23: mode fixed at reset, mii default
//////////////////////////////////////////////////////////////////////////////////////////////
module phy_mac_side #(
    parameter int unsigned SQE_LEN = mac_if_pkg::SQE_CYCLES
) (
    input  wire logic       ref_clk_i,       // system clock
    input  wire logic       rst_i,           // sync reset
    input  wire logic [1:0] mode_strap_i,    // interface mode strap
    input  wire logic       speed_100_i,     // 1 = 100 Mb/s
    input  wire logic       full_duplex_i,   // 1 = full duplex
    input  wire logic       heartbeat_en_i,  // sqe test enable
    input  wire logic       line_rx_act_i,   // medium non-idle
    input  wire logic       line_rx_valid_i, // decoded data valid
    input  wire logic       line_rx_err_i,   // symbol or media error
    input  wire logic [3:0] line_rxd_i,      // decoded receive data
    output logic            tx_valid_o,      // sampled tx data valid
    output logic [3:0]      tx_data_o,       // sampled tx data
    mac_data_if.phy         mac              // mac side pins
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_TX   = 3'b010,
        ST_SQE  = 3'b100
    } tx_state_e;

    logic [1:0]  mode;
    logic [mac_if_pkg::DIV_W-1:0] div_cnt;
    logic        clk_lvl;
    logic        tx_en_s1, tx_en_s2;
    logic [3:0]  txd_s1, txd_s2;
    logic        act_s1, act_s2, val_s1, val_s2, err_s1, err_s2;
    logic [3:0]  lrxd_s1, lrxd_s2;
    logic [31:0] sqe_cnt;
    tx_state_e   tx_state, next_tx_state;
    logic        rx_dv_q, rx_er_q, crs_q, col_q;
    logic [3:0]  rxd_q;

    wire is_rmii = (mode == mac_if_pkg::MODE_RMII);
    wire is_ser  = (mode == mac_if_pkg::MODE_SER);
    wire is_mii  = !is_rmii && !is_ser;
    // R1: R3: R8: clock half period by mode and speed
    wire [mac_if_pkg::DIV_W-1:0] half =
        is_rmii ? mac_if_pkg::DIV_W'(mac_if_pkg::HALF_RMII) :
        is_ser  ? mac_if_pkg::DIV_W'(mac_if_pkg::HALF_SER)  :
        speed_100_i ? mac_if_pkg::DIV_W'(mac_if_pkg::HALF_100) :
                      mac_if_pkg::DIV_W'(mac_if_pkg::HALF_10);
    wire half_end  = (div_cnt == half - mac_if_pkg::DIV_W'(1));
    // R6: R7: sample on rising edge of the link clock
    wire rise      = half_end && !clk_lvl;
    wire fall      = half_end && clk_lvl;
    wire err_100   = err_s2 && speed_100_i && !is_ser;
    wire tx_act    = (tx_state == ST_TX);
    // R19: R21: overlap collision in half duplex only
    wire overlap   = !full_duplex_i && !is_rmii && tx_act && act_s2;

    // R23: mode caught at reset, mii unless strapped
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mode <= (mode_strap_i == mac_if_pkg::MODE_RMII || mode_strap_i == mac_if_pkg::MODE_SER)
                    ? mode_strap_i : mac_if_pkg::MODE_MII;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || half_end) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + mac_if_pkg::DIV_W'(1);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            clk_lvl <= 1'b0;
        end else if (half_end) begin
            clk_lvl <= !clk_lvl;
        end
    end

    // R2: clock outputs idle low in rmii
    assign mac.tx_clk = clk_lvl && !is_rmii;
    assign mac.rx_clk = clk_lvl && !is_rmii;

    always_ff @(posedge ref_clk_i) begin
        tx_en_s1 <= mac.tx_en;
        tx_en_s2 <= tx_en_s1;
        txd_s1   <= mac.txd;
        txd_s2   <= txd_s1;
        act_s1   <= line_rx_act_i;
        act_s2   <= act_s1;
        val_s1   <= line_rx_valid_i;
        val_s2   <= val_s1;
        err_s1   <= line_rx_err_i;
        err_s2   <= err_s1;
        lrxd_s1  <= line_rxd_i;
        lrxd_s2  <= lrxd_s1;
    end

    // R6: R7: R4: capture tx data at link clock rise
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            tx_valid_o <= 1'b0;
            tx_data_o  <= '0;
        end else if (rise) begin
            tx_valid_o <= tx_en_s2;
            tx_data_o  <= is_rmii ? {2'h0, txd_s2[1:0]} :
                          is_ser  ? {3'h0, txd_s2[0]} : txd_s2;
        end
    end

    // R20: heartbeat after each transmission at 10M half duplex, mii or serial
    always_comb begin
        next_tx_state = tx_state;
        case (tx_state)
            ST_IDLE: if (rise && tx_en_s2) next_tx_state = ST_TX;
            ST_TX:   if (rise && !tx_en_s2) begin
                next_tx_state = (heartbeat_en_i && !speed_100_i && !full_duplex_i && !is_rmii)
                                ? ST_SQE : ST_IDLE;
            end
            ST_SQE:  if (sqe_cnt >= SQE_LEN - 1) next_tx_state = ST_IDLE;
            default: next_tx_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            tx_state <= ST_IDLE;
            sqe_cnt  <= '0;
        end else begin
            tx_state <= next_tx_state;
            sqe_cnt  <= (tx_state == ST_SQE) ? sqe_cnt + 32'h1 : 32'h0;
        end
    end

    // receive outputs change at link clock fall (rise in rmii); collision updates every cycle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rx_dv_q <= 1'b0;
            rx_er_q <= 1'b0;
            rxd_q   <= '0;
            crs_q   <= 1'b0;
            col_q   <= 1'b0;
        end else begin
            col_q <= overlap || (tx_state == ST_SQE);
            if (is_rmii ? rise : fall) begin
                // R9: R10: valid follows decoded data only
                rx_dv_q <= !is_ser && val_s2;
                // R11: R12: error only within valid data at 100M
                rx_er_q <= err_100 && val_s2;
                // R13: R14: R15: R16: data lanes per mode
                if (err_100 && val_s2) begin
                    rxd_q <= is_rmii ? {2'h0, mac_if_pkg::ERR_NIBBLE[1:0]}
                                     : mac_if_pkg::ERR_NIBBLE;
                end else if (is_rmii) begin
                    rxd_q <= {2'h0, lrxd_s2[1:0]};
                end else if (is_ser) begin
                    rxd_q <= {3'h0, lrxd_s2[0]};
                end else begin
                    rxd_q <= lrxd_s2;
                end
                // R17: R18: carrier, combined with valid in rmii
                crs_q <= is_rmii ? (act_s2 || val_s2) : act_s2;
            end
        end
    end

    assign mac.rx_dv = rx_dv_q;
    assign mac.rx_er = rx_er_q;
    assign mac.rxd   = rxd_q;
    assign mac.crs   = crs_q;
    assign mac.col   = col_q;
endmodule
